// ===== design/tcpob_bank.sv
// tcpob_bank: register bank that configures, commands and monitors the tcp offload engine
// assumes a bus-to-register converter on ref_clk issuing write strobes and read requests
// Functional notes
// - offset 0x00 bit0 drives engine reset_n
// - offset 0x04 gives arp enable, mac mode
// - local mac from 0x08 low, 0x0c high
// - remote mac from 0x10 low, 0x14 high
// - local ip 0x18, remote ip 0x1c
// - offset 0x20 sets engine timeout value
// - 0x24 bit0 one clears sticky irq flag
// - 0x30 bits 1:0 drive tcp command
// - ports from 0x34 and 0x38 low halves
// - engine irq sets sticky status bit two
// - status gives state, open and init flags
// - 0x48 returns full interrupt cause vector
// - learned remote mac at 0x4c, 0x50
// - engine version 0x40, mac version 0x60
// - 0x64 bit0 shows mac link up
// - every write to a config register performed, every read answered
`timescale 1ns/1ps
module tcpob_bank (
	input  wire logic                         ref_clk,
	input  wire logic                         srst,
	input  wire tcpob_pkg::tcpob_req_t        req,
	output logic                              rd_valid,
	output logic      [tcpob_pkg::DATA_W-1:0] rd_data,
	output tcpob_pkg::tcpob_cfg_t             cfg,
	input  wire tcpob_pkg::tcpob_stat_t       stat_async
);
	import tcpob_pkg::*;

	typedef struct packed {
		tcpob_cfg_t           cfg;
		logic                 irq_flag;
		logic                 rd_req;
		logic [ADDR_W-1:0]    rd_addr;
		logic                 rd_valid;
		logic [DATA_W-1:0]    rd_data;
	} tcpob_bank_st_t;

	tcpob_bank_st_t st_q;
	tcpob_bank_st_t st_d;
	tcpob_stat_t    stat;
	logic [DATA_W-1:0] mux_data;
	logic              wr;
	logic [DATA_W-1:0] wd;
	logic [BE_W-1:0]   be;
	logic [DATA_W-1:0] tmp;

	// status crosses from engine and mac clocks
	tcpob_sync #(
		.W ($bits(tcpob_stat_t))
	) u_sync (
		.ref_clk (ref_clk),
		.srst    (srst),
		.din     (stat_async),
		.dout    (stat)
	);

	tcpob_rdmux u_rdmux (
		.addr     (st_q.rd_addr),
		.stat     (stat),
		.irq_flag (st_q.irq_flag),
		.rd_data  (mux_data)
	);

	assign wr = req.wr_en;
	assign wd = req.wr_data;
	assign be = req.wr_byte_en;

	always_comb begin
		st_d = st_q;
		tmp  = '0;

		// read pipeline, answer two cycles on
		st_d.rd_req   = req.rd_req;
		st_d.rd_valid = st_q.rd_req;
		if (req.rd_req) begin
			st_d.rd_addr = req.addr;
		end
		st_d.rd_data = st_q.rd_req ? mux_data : '0;

		if (wr && tcpob_hit(req.addr, OFF_ENGINE_RESET_CTRL)) begin
			tmp = tcpob_merge({31'h0, st_q.cfg.engine_reset_n}, wd, be);
			st_d.cfg.engine_reset_n = tmp[RST_N_BIT];
		end

		if (wr && tcpob_hit(req.addr, OFF_ENGINE_OP_MODE)) begin
			tmp = '0;
			tmp[ARP_EN_BIT] = st_q.cfg.arp_icmp_reply_en;
			tmp[MODE_LSB +: MODE_W] = st_q.cfg.remote_mac_resolve_mode;
			tmp = tcpob_merge(tmp, wd, be);
			st_d.cfg.arp_icmp_reply_en = tmp[ARP_EN_BIT];
			st_d.cfg.remote_mac_resolve_mode = tmp[MODE_LSB +: MODE_W];
		end

		if (wr && tcpob_hit(req.addr, OFF_LOCAL_MAC_LOW)) begin
			st_d.cfg.local_mac_addr[31:0] = tcpob_merge(st_q.cfg.local_mac_addr[31:0], wd, be);
		end
		if (wr && tcpob_hit(req.addr, OFF_LOCAL_MAC_HIGH)) begin
			tmp = tcpob_merge({16'h0, st_q.cfg.local_mac_addr[47:32]}, wd, be);
			st_d.cfg.local_mac_addr[47:32] = tmp[MAC_HI_W-1:0];
		end

		if (wr && tcpob_hit(req.addr, OFF_REMOTE_MAC_IN_LOW)) begin
			st_d.cfg.remote_mac_addr_in[31:0] = tcpob_merge(st_q.cfg.remote_mac_addr_in[31:0], wd, be);
		end
		if (wr && tcpob_hit(req.addr, OFF_REMOTE_MAC_IN_HIGH)) begin
			tmp = tcpob_merge({16'h0, st_q.cfg.remote_mac_addr_in[47:32]}, wd, be);
			st_d.cfg.remote_mac_addr_in[47:32] = tmp[MAC_HI_W-1:0];
		end

		if (wr && tcpob_hit(req.addr, OFF_LOCAL_IP)) begin
			st_d.cfg.local_ip_addr = tcpob_merge(st_q.cfg.local_ip_addr, wd, be);
		end
		if (wr && tcpob_hit(req.addr, OFF_REMOTE_IP)) begin
			st_d.cfg.remote_ip_addr = tcpob_merge(st_q.cfg.remote_ip_addr, wd, be);
		end

		if (wr && tcpob_hit(req.addr, OFF_TIMEOUT_VALUE)) begin
			st_d.cfg.timeout_value = tcpob_merge(st_q.cfg.timeout_value, wd, be);
		end

		if (wr && tcpob_hit(req.addr, OFF_TCP_COMMAND)) begin
			tmp = tcpob_merge({30'h0, st_q.cfg.tcp_command}, wd, be);
			st_d.cfg.tcp_command = tmp[CMD_LSB +: CMD_W];
		end

		if (wr && tcpob_hit(req.addr, OFF_LOCAL_PORT)) begin
			tmp = tcpob_merge({16'h0, st_q.cfg.local_tcp_port}, wd, be);
			st_d.cfg.local_tcp_port = tmp[PORT_W-1:0];
		end
		if (wr && tcpob_hit(req.addr, OFF_REMOTE_PORT)) begin
			tmp = tcpob_merge({16'h0, st_q.cfg.remote_tcp_port}, wd, be);
			st_d.cfg.remote_tcp_port = tmp[PORT_W-1:0];
		end

		if (wr && tcpob_hit(req.addr, OFF_IRQ_FLAG_CLEAR) && be[0] && wd[CLR_BIT]) begin
			st_d.irq_flag = 1'b0;
		end
		// set after clear, so set wins
		// level set: while irq is held, a clear in the same cycle loses and the flag stays set
		if (stat.engine_irq) begin
			st_d.irq_flag = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_q <= '0;
			st_q.cfg.engine_reset_n <= RST_N_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign rd_valid = st_q.rd_valid;
	assign rd_data  = st_q.rd_data;
	assign cfg      = st_q.cfg;

endmodule : tcpob_bank

// ===== design/tcpob_rdmux.sv
// tcpob_rdmux: read data selection for the readable registers
// assumes status already synchronised; result is registered by the caller
`timescale 1ns/1ps
module tcpob_rdmux (
	input  wire logic [tcpob_pkg::ADDR_W-1:0] addr,
	input  wire tcpob_pkg::tcpob_stat_t       stat,
	input  wire logic                         irq_flag,
	output logic      [tcpob_pkg::DATA_W-1:0] rd_data
);
	import tcpob_pkg::*;

	always_comb begin
		rd_data = '0;
		if (tcpob_hit(addr, OFF_ENGINE_VERSION)) begin
			rd_data = stat.engine_version;
		end
		if (tcpob_hit(addr, OFF_ENGINE_STATUS)) begin
			rd_data[STS_STATE_LSB +: STS_STATE_W] = stat.engine_state_code;
			rd_data[STS_CONN_BIT] = stat.connection_open;
			rd_data[STS_INIT_BIT] = stat.init_complete;
			rd_data[STS_IRQ_BIT] = irq_flag;
		end
		if (tcpob_hit(addr, OFF_INTERRUPT_CAUSE)) begin
			rd_data = stat.irq_cause_vector;
		end
		if (tcpob_hit(addr, OFF_LEARNED_MAC_LOW)) begin
			rd_data = stat.learned_remote_mac[31:0];
		end
		if (tcpob_hit(addr, OFF_LEARNED_MAC_HIGH)) begin
			rd_data[MAC_HI_W-1:0] = stat.learned_remote_mac[47:32];
		end
		if (tcpob_hit(addr, OFF_MAC_VERSION)) begin
			rd_data = stat.mac_version;
		end
		if (tcpob_hit(addr, OFF_MAC_LINK_STATUS)) begin
			rd_data[LINK_BIT] = stat.mac_link_up;
		end
	end

endmodule : tcpob_rdmux

// ===== design/tcpob_sync.sv
// tcpob_sync: three-stage synchroniser for engine and mac status
// assumes inputs are quasi-static words or levels from foreign clocks
`timescale 1ns/1ps
module tcpob_sync #(
	parameter int W = 8
) (
	input  wire logic         ref_clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	import tcpob_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] o;
	} tcpob_sync_st_t;

	tcpob_sync_st_t st_q;
	tcpob_sync_st_t st_d;

	// per bit: a change is taken only once stages two and three agree
	// limitation: multi-bit words may show a mix of old and new bits for a few cycles
	always_comb begin
		st_d    = st_q;
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		for (int i = 0; i < W; i++) begin
			if (st_q.s2[i] == st_q.s3[i]) begin
				st_d.o[i] = st_q.s3[i];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.o;

endmodule : tcpob_sync

// ===== dv/tcpob_bank_assertions.sv
// tcpob_chk: port checker for the offload register bank
// assumes full-word writes for the field relations
`timescale 1ns/1ps
module tcpob_chk (
	input wire logic                         ref_clk,
	input wire logic                         srst,
	input wire tcpob_pkg::tcpob_req_t        req,
	input wire logic                         rd_valid,
	input wire logic [tcpob_pkg::DATA_W-1:0] rd_data,
	input wire tcpob_pkg::tcpob_cfg_t        cfg
);
	import tcpob_pkg::*;
	logic wf;
	assign wf = req.wr_en && (req.wr_byte_en == 4'hf);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	AST_RD_LAT: assert property (req.rd_req |-> ##2 rd_valid)
		else $error("read not answered");
	AST_RD_CAUSE: assert property (rd_valid |-> $past(req.rd_req, 2))
		else $error("read answer without request");
	AST_IDLE_ZERO: assert property (!rd_valid |-> rd_data == 32'h0)
		else $error("read data not zero while idle");
	AST_RST_BIT: assert property (wf && tcpob_hit(req.addr, OFF_ENGINE_RESET_CTRL)
		|=> cfg.engine_reset_n == $past(req.wr_data[0])) else $error("engine reset bit wrong");
	AST_MODE: assert property (wf && tcpob_hit(req.addr, OFF_ENGINE_OP_MODE)
		|=> {cfg.arp_icmp_reply_en, cfg.remote_mac_resolve_mode} == {$past(req.wr_data[16]),
		$past(req.wr_data[1:0])}) else $error("mode fields wrong");
	AST_MAC_HIGH: assert property (wf && tcpob_hit(req.addr, OFF_LOCAL_MAC_HIGH)
		|=> cfg.local_mac_addr[47:32] == $past(req.wr_data[15:0])) else $error("mac high wrong");
	AST_REM_IP: assert property (wf && tcpob_hit(req.addr, OFF_REMOTE_IP)
		|=> cfg.remote_ip_addr == $past(req.wr_data)) else $error("remote ip wrong");
	AST_CMD: assert property (wf && tcpob_hit(req.addr, OFF_TCP_COMMAND)
		|=> cfg.tcp_command == $past(req.wr_data[1:0])) else $error("command wrong");
	AST_KEEP: assert property (!req.wr_en |=> $stable(cfg))
		else $error("config changed without write");
	AST_WO_ZERO: assert property (req.rd_req && tcpob_hit(req.addr, OFF_TIMEOUT_VALUE)
		|-> ##2 rd_data == 32'h0) else $error("write-only read not zero");
endmodule : tcpob_chk

bind tcpob_bank tcpob_chk i_tcpob_chk (.ref_clk(ref_clk), .srst(srst), .req(req),
	.rd_valid(rd_valid), .rd_data(rd_data), .cfg(cfg));

// ===== dv/tcpob_bank_tb_top.sv
// tcpob_bank_tb_top: directed register tests of the offload register bank
// assumes the engine model on the status side
`timescale 1ns/1ps
module tcpob_bank_tb_top;
	import tcpob_pkg::*;
	localparam logic [31:0] EV = 32'h0000_0101;
	localparam logic [31:0] MV = 32'h0000_0202;
	localparam logic [31:0] CS = 32'h8000_0013;
	logic              ref_clk = 1'b0;
	logic              srst = 1'b1;
	tcpob_req_t        req = '0;
	logic              rd_valid;
	logic [DATA_W-1:0] rd_data;
	tcpob_cfg_t        cfg;
	tcpob_cfg_t        c0;
	tcpob_stat_t       stat;
	logic              irq = 1'b0;
	logic              link = 1'b0;
	logic [4:0]        st = 5'h15;
	int                fails = 0;
	int                comparisons = 0;
	always #2.5 ref_clk = ~ref_clk;
	tcpob_bank i_tcpob_bank (.ref_clk(ref_clk), .srst(srst), .req(req), .rd_valid(rd_valid),
		.rd_data(rd_data), .cfg(cfg), .stat_async(stat));
	tcpob_engine_model #(.EV(EV), .MV(MV), .CAUSE(CS)) i_tcpob_engine_model (.ref_clk(ref_clk),
		.cfg(cfg), .irq(irq), .link_up(link), .state_code(st), .stat(stat));
	task automatic wrap_up();
		$display("counts: %0d comparisons, %0d fails", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrb(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [BE_W-1:0] be);
		@(negedge ref_clk) req = '{1'b1, 1'b0, a, d, be};
		@(negedge ref_clk) req.wr_en = 1'b0;
		@(negedge ref_clk);
	endtask : wrb
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		wrb(a, d, 4'hf);
	endtask : wr
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		int n;
		@(negedge ref_clk) req = '{1'b0, 1'b1, a, 32'h0, 4'h0};
		@(negedge ref_clk) req.rd_req = 1'b0;
		n = 0;
		while (rd_valid !== 1'b1 && n < 4) begin
			@(negedge ref_clk);
			n++;
		end
		if (n == 4) begin
			fails++;
			$display("mismatch at %0t: no read answer", $time);
			wrap_up();
		end else begin
			chk(rd_data, exp);
		end
	endtask : rdc
	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : idle
	initial begin
		logic [1:0] k;
		idle(6);
		srst = 1'b0;
		chk(cfg.engine_reset_n, 1'b0);
		wr(OFF_ENGINE_RESET_CTRL, 32'hffff_fffe);
		chk(cfg.engine_reset_n, 1'b0);
		wr(OFF_ENGINE_RESET_CTRL, 32'h0000_0001);
		chk(cfg.engine_reset_n, 1'b1);
		for (int i = 0; i < 4; i++) begin
			k = 2'(i);
			wr(OFF_ENGINE_OP_MODE, {15'h0, k[0], 14'h2aaa, k});
			chk({cfg.arp_icmp_reply_en, cfg.remote_mac_resolve_mode}, {k[0], k});
			wr(OFF_TCP_COMMAND, {30'h2aaa_aaaa, k});
			chk(cfg.tcp_command, k);
		end
		wr(OFF_LOCAL_MAC_LOW, 32'h3344_5566);
		wr(OFF_LOCAL_MAC_HIGH, 32'habcd_1122);
		chk(cfg.local_mac_addr, 48'h1122_3344_5566);
		wr(OFF_REMOTE_MAC_IN_LOW, 32'h0a0b_0c0d);
		wr(OFF_REMOTE_MAC_IN_HIGH, 32'hffff_0e0f);
		chk(cfg.remote_mac_addr_in, 48'h0e0f_0a0b_0c0d);
		wr(OFF_LOCAL_IP, 32'hc0a8_0719);
		wr(OFF_REMOTE_IP, 32'hc0a8_0764);
		chk({cfg.local_ip_addr, cfg.remote_ip_addr[15:0]}, 48'hc0a8_0719_0764);
		wr(OFF_TIMEOUT_VALUE, 32'h0001_e848);
		chk(cfg.timeout_value, 32'h0001_e848);
		wrb(OFF_TIMEOUT_VALUE, 32'hffff_ff00, 4'h2);
		chk(cfg.timeout_value, 32'h0001_ff48);
		wr(OFF_LOCAL_PORT, 32'h5555_1234);
		wr(OFF_REMOTE_PORT, 32'haaaa_0050);
		chk({cfg.local_tcp_port, cfg.remote_tcp_port}, 32'h1234_0050);
		$display("test config writes done");
		c0 = cfg;
		wr(18'h00028, 32'hffff_ffff);
		wr(OFF_ENGINE_VERSION, 32'hffff_ffff);
		chk(cfg === c0, 1'b1);
		rdc(OFF_LOCAL_IP, 32'h0);
		rdc(18'h3fffc, 32'h0);
		$display("test unmapped done");
		link = 1'b1;
		idle(8);
		rdc(OFF_ENGINE_STATUS, {11'h0, 5'h15, 13'h0, 3'b011});
		rdc(OFF_ENGINE_VERSION, EV);
		rdc(OFF_MAC_VERSION + 18'h2, MV);
		rdc(OFF_INTERRUPT_CAUSE, CS);
		rdc(OFF_LEARNED_MAC_LOW, 32'h0a0b_0c0d);
		rdc(OFF_LEARNED_MAC_HIGH, 32'h0000_0e0f);
		rdc(OFF_MAC_LINK_STATUS, 32'h1);
		link = 1'b0;
		idle(8);
		rdc(OFF_MAC_LINK_STATUS, 32'h0);
		$display("test status done");
		irq = 1'b1;
		idle(8);
		wr(OFF_IRQ_FLAG_CLEAR, 32'h1);
		rdc(OFF_ENGINE_STATUS, {11'h0, 5'h15, 13'h0, 3'b111});
		irq = 1'b0;
		idle(8);
		rdc(OFF_ENGINE_STATUS, {11'h0, 5'h15, 13'h0, 3'b111});
		wr(OFF_IRQ_FLAG_CLEAR, 32'hffff_fffe);
		rdc(OFF_ENGINE_STATUS, {11'h0, 5'h15, 13'h0, 3'b111});
		wrb(OFF_IRQ_FLAG_CLEAR, 32'h0000_0001, 4'he);
		rdc(OFF_ENGINE_STATUS, {11'h0, 5'h15, 13'h0, 3'b111});
		wr(OFF_IRQ_FLAG_CLEAR, 32'h1);
		rdc(OFF_ENGINE_STATUS, {11'h0, 5'h15, 13'h0, 3'b011});
		$display("test irq flag done");
		srst = 1'b1;
		idle(6);
		srst = 1'b0;
		chk(cfg === '0, 1'b1);
		idle(8);
		rdc(OFF_ENGINE_STATUS, {11'h0, 5'h15, 13'h0, 3'b000});
		$display("test reset done");
		wrap_up();
	end
endmodule : tcpob_bank_tb_top

// ===== dv/tcpob_engine_model.sv
// tcpob_engine_model: offload engine and mac status as seen by the bank
// assumes one-cycle registered status, irq and link driven by the bench
`timescale 1ns/1ps
module tcpob_engine_model #(
	parameter logic [31:0] EV = 32'h0000_0101, // arbitrary
	parameter logic [31:0] MV = 32'h0000_0202, // arbitrary
	parameter logic [31:0] CAUSE = 32'h8000_0013
) (
	input  wire logic                  ref_clk,
	input  wire tcpob_pkg::tcpob_cfg_t cfg,
	input  wire logic                  irq,
	input  wire logic                  link_up,
	input  wire logic [4:0]            state_code,
	output tcpob_pkg::tcpob_stat_t     stat
);
	import tcpob_pkg::*;
	// learned mac mirrors the given one, open flag follows command bit 0
	always_ff @(posedge ref_clk) begin
		stat <= '{EV, state_code, irq, cfg.tcp_command[0], cfg.engine_reset_n, CAUSE,
			cfg.remote_mac_addr_in, MV, link_up};
	end
endmodule : tcpob_engine_model

// ===== pkg/tcpob_pkg.sv
// tcpob_pkg: offsets, field positions, reset values and carrier types of the offload register bank
// assumes byte addresses on an 18-bit word-aligned register port, 32-bit data
package tcpob_pkg;

	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;
	localparam int BE_W   = 4;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_ENGINE_RESET_CTRL   = 18'h00000;
	localparam logic [ADDR_W-1:0] OFF_ENGINE_OP_MODE      = 18'h00004;
	localparam logic [ADDR_W-1:0] OFF_LOCAL_MAC_LOW       = 18'h00008;
	localparam logic [ADDR_W-1:0] OFF_LOCAL_MAC_HIGH      = 18'h0000c;
	localparam logic [ADDR_W-1:0] OFF_REMOTE_MAC_IN_LOW   = 18'h00010;
	localparam logic [ADDR_W-1:0] OFF_REMOTE_MAC_IN_HIGH  = 18'h00014;
	localparam logic [ADDR_W-1:0] OFF_LOCAL_IP            = 18'h00018;
	localparam logic [ADDR_W-1:0] OFF_REMOTE_IP           = 18'h0001c;
	localparam logic [ADDR_W-1:0] OFF_TIMEOUT_VALUE       = 18'h00020;
	localparam logic [ADDR_W-1:0] OFF_IRQ_FLAG_CLEAR      = 18'h00024;
	localparam logic [ADDR_W-1:0] OFF_TCP_COMMAND         = 18'h00030;
	localparam logic [ADDR_W-1:0] OFF_LOCAL_PORT          = 18'h00034;
	localparam logic [ADDR_W-1:0] OFF_REMOTE_PORT         = 18'h00038;
	localparam logic [ADDR_W-1:0] OFF_ENGINE_VERSION      = 18'h00040;
	localparam logic [ADDR_W-1:0] OFF_ENGINE_STATUS       = 18'h00044;
	localparam logic [ADDR_W-1:0] OFF_INTERRUPT_CAUSE     = 18'h00048;
	localparam logic [ADDR_W-1:0] OFF_LEARNED_MAC_LOW     = 18'h0004c;
	localparam logic [ADDR_W-1:0] OFF_LEARNED_MAC_HIGH    = 18'h00050;
	localparam logic [ADDR_W-1:0] OFF_MAC_VERSION         = 18'h00060;
	localparam logic [ADDR_W-1:0] OFF_MAC_LINK_STATUS     = 18'h00064;

	// field positions
	localparam int RST_N_BIT      = 0;
	localparam int ARP_EN_BIT     = 16;
	localparam int MODE_LSB       = 0;
	localparam int MODE_W         = 2;
	localparam int CLR_BIT        = 0;
	localparam int CMD_LSB        = 0;
	localparam int CMD_W          = 2;
	localparam int PORT_W         = 16;
	localparam int MAC_HI_W       = 16;
	localparam int STS_STATE_LSB  = 16;
	localparam int STS_STATE_W    = 5;
	localparam int STS_IRQ_BIT    = 2;
	localparam int STS_CONN_BIT   = 1;
	localparam int STS_INIT_BIT   = 0;
	localparam int LINK_BIT       = 0;

	// reset value of the engine reset bit: engine held in reset until software releases it
	localparam logic RST_N_RESET  = 1'b0;

	typedef struct packed {
		logic                  wr_en;
		logic                  rd_req;
		logic [ADDR_W-1:0]     addr;
		logic [DATA_W-1:0]     wr_data;
		logic [BE_W-1:0]       wr_byte_en;
	} tcpob_req_t;

	typedef struct packed {
		logic                  engine_reset_n;
		logic                  arp_icmp_reply_en;
		logic [MODE_W-1:0]     remote_mac_resolve_mode;
		logic [47:0]           local_mac_addr;
		logic [47:0]           remote_mac_addr_in;
		logic [31:0]           local_ip_addr;
		logic [31:0]           remote_ip_addr;
		logic [31:0]           timeout_value;
		logic [CMD_W-1:0]      tcp_command;
		logic [PORT_W-1:0]     local_tcp_port;
		logic [PORT_W-1:0]     remote_tcp_port;
	} tcpob_cfg_t;

	typedef struct packed {
		logic [31:0]           engine_version;
		logic [STS_STATE_W-1:0] engine_state_code;
		logic                  engine_irq;
		logic                  connection_open;
		logic                  init_complete;
		logic [31:0]           irq_cause_vector;
		logic [47:0]           learned_remote_mac;
		logic [31:0]           mac_version;
		logic                  mac_link_up;
	} tcpob_stat_t;

	// word match of a byte address against a register offset
	function automatic logic tcpob_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		tcpob_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
	endfunction : tcpob_hit

	// byte-lane merge of a write into an old value
	function automatic logic [DATA_W-1:0] tcpob_merge(input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] wd, input logic [BE_W-1:0] be);
		logic [DATA_W-1:0] r;
		r = old;
		for (int i = 0; i < BE_W; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		tcpob_merge = r;
	endfunction : tcpob_merge

endpackage : tcpob_pkg
